/* port_pin_function_mux.sv */
// Functional notes
// R01 - each covered pin is software input or push-pull output, optional pull-up
// R02 - port b bits 6 and 3 also offer an independent pull-down
// R03 - port a bit 3 serves adc channel 8 and comparator minus source 0
// R04 - second timer pwm routes to port a bit 3, port b bits 4 and 2
// R05 - third timer pwm routes to port b bits 7, 6 and 5
// R06 - port a bit 0 serves adc channel 10, comparator output, irq line 0
// R07 - external irq lines trigger on rising or falling edge, chosen by register
// R08 - port b bit 5 is alternate irq line 0 source and adc channel 5
// R09 - port b bits 7, 6 serve comparator minus 5, 4 and adc channels 7, 6
// R10 - port b bits 4, 3, 2 serve adc channels 4, 3, 2
// R11 - input enable cleared disables input buffer and power-down wake-up
// R12 - port a bit 0 input enable cleared stops its toggle wake-up
// R13 - enabled pin level change in power-down raises a wake-up request
`timescale 1ns/1ps
module port_pin_function_mux
  import pin_mux_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic [7:0] port_a_pin_in, // port a pad levels
  input wire logic [7:0] port_b_pin_in, // port b pad levels
  output pad_ctrl_s port_a_pad, // port a pad controls
  output pad_ctrl_s port_b_pad, // port b pad controls
  input wire logic second_timer_pwm_out, // pwm from second timer
  input wire logic third_timer_pwm_out, // pwm from third timer
  input wire logic comparator_result, // comparator result
  output logic [ADC_CH_W-1:0] adc_channel_en, // analog switch per adc channel
  output logic [CMPN_W-1:0] comparator_neg_en, // comparator minus source switches
  output logic ext_irq_line_zero, // gated level of irq line 0 source
  output logic ext_irq_req, // one-cycle irq line 0 edge request
  input wire logic power_down, // chip in power-down
  output logic wake_req, // wake-up request to power control
  output logic irq // level interrupt
);

  logic [7:0] pa_ie, pb_ie, pa_data, pa_dir, pa_pu;
  logic [7:0] pb_data, pb_dir, pb_pu, pb_pd;
  logic [ALT_W-1:0] alt_ctrl;
  logic [ANA_W-1:0] analog_en;
  logic [IRQ_W-1:0] irq_stat, irq_mask, irq_set;
  logic [7:0] pa_sample, pb_sample, pa_prev, pb_prev;
  logic irq0_prev;
  logic wr_en, rd_en;
  logic [7:0] wr_byte;
  logic [7:0] pa_ana, pb_ana, pa_alt_en, pb_alt_en, pa_alt_val, pb_alt_val;
  logic next_irq0, irq0_event, wake_event;
  pad_ctrl_s next_pa, next_pb;
  logic [ADC_CH_W-1:0] next_adc;
  logic [CMPN_W-1:0] next_cmpn;

  // true when the byte address hits a register
  function automatic logic is_mapped(input logic [7:0] a);
    unique case (a)
      OFS_PA_IE, OFS_PB_IE, OFS_PA_DATA, OFS_PA_DIR, OFS_PA_PU,
      OFS_PB_DATA, OFS_PB_DIR, OFS_PB_PU, OFS_PB_PD, OFS_ALT,
      OFS_ANALOG, OFS_PA_IN, OFS_PB_IN, OFS_IRQ_STAT, OFS_IRQ_MASK: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // write strobe for one register
  function automatic logic hit(input logic en, input logic [7:0] a, input logic [7:0] ofs);
    hit = en && (a == ofs);
  endfunction

  // access phase strobes, one wait state per transfer
  assign wr_en = psel && penable && !pready && pwrite && is_mapped(paddr);
  assign rd_en = psel && penable && !pready && !pwrite;
  assign wr_byte = pwdata[7:0];

  // apb handshake and error
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !is_mapped(paddr);
    end
  end

  // input enable registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pa_ie <= IE_RESET & PA_MASK;
      pb_ie <= IE_RESET & PB_MASK;
    end else begin
      if (hit(wr_en, paddr, OFS_PA_IE)) pa_ie <= wr_byte & PA_MASK;
      if (hit(wr_en, paddr, OFS_PB_IE)) pb_ie <= wr_byte & PB_MASK;
    end
  end

  // port data, direction and pull registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pa_data <= CFG_RESET;
      pa_dir <= CFG_RESET;
      pa_pu <= CFG_RESET;
      pb_data <= CFG_RESET;
      pb_dir <= CFG_RESET;
      pb_pu <= CFG_RESET;
      pb_pd <= CFG_RESET;
    end else begin
      if (hit(wr_en, paddr, OFS_PA_DATA)) pa_data <= wr_byte & PA_MASK; // R01
      if (hit(wr_en, paddr, OFS_PA_DIR)) pa_dir <= wr_byte & PA_MASK; // R01
      if (hit(wr_en, paddr, OFS_PA_PU)) pa_pu <= wr_byte & PA_MASK; // R01
      if (hit(wr_en, paddr, OFS_PB_DATA)) pb_data <= wr_byte & PB_MASK; // R01
      if (hit(wr_en, paddr, OFS_PB_DIR)) pb_dir <= wr_byte & PB_MASK; // R01
      if (hit(wr_en, paddr, OFS_PB_PU)) pb_pu <= wr_byte & PB_MASK; // R01
      if (hit(wr_en, paddr, OFS_PB_PD)) pb_pd <= wr_byte & PB_PD_MASK; // R02
    end
  end

  // alternate function, analog selection and interrupt mask registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      alt_ctrl <= '0;
      analog_en <= '0;
      irq_mask <= '0;
    end else begin
      if (hit(wr_en, paddr, OFS_ALT)) alt_ctrl <= pwdata[ALT_W-1:0];
      if (hit(wr_en, paddr, OFS_ANALOG)) begin
        analog_en <= {pwdata[ANA_PB_LSB +: 8] & PB_MASK, pwdata[7:0] & PA_MASK};
      end
      if (hit(wr_en, paddr, OFS_IRQ_MASK)) irq_mask <= pwdata[IRQ_W-1:0];
    end
  end

  // read data mux
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= '0;
    end else if (rd_en) begin
      unique case (paddr)
        OFS_PA_IE: prdata <= {24'h000000, pa_ie};
        OFS_PB_IE: prdata <= {24'h000000, pb_ie};
        OFS_PA_DATA: prdata <= {24'h000000, pa_data};
        OFS_PA_DIR: prdata <= {24'h000000, pa_dir};
        OFS_PA_PU: prdata <= {24'h000000, pa_pu};
        OFS_PB_DATA: prdata <= {24'h000000, pb_data};
        OFS_PB_DIR: prdata <= {24'h000000, pb_dir};
        OFS_PB_PU: prdata <= {24'h000000, pb_pu};
        OFS_PB_PD: prdata <= {24'h000000, pb_pd};
        OFS_ALT: prdata <= {{(32-ALT_W){1'b0}}, alt_ctrl};
        OFS_ANALOG: prdata <= {{(32-ANA_W){1'b0}}, analog_en};
        OFS_PA_IN: prdata <= {24'h000000, pa_sample};
        OFS_PB_IN: prdata <= {24'h000000, pb_sample};
        OFS_IRQ_STAT: prdata <= {{(32-IRQ_W){1'b0}}, irq_stat};
        OFS_IRQ_MASK: prdata <= {{(32-IRQ_W){1'b0}}, irq_mask};
        default: prdata <= '0;
      endcase
    end
  end

  // alternate output routing per pin
  always_comb begin
    pa_ana = analog_en[7:0];
    pb_ana = analog_en[ANA_PB_LSB +: 8];
    pa_alt_en = '0;
    pb_alt_en = '0;
    pa_alt_val = '0;
    pb_alt_val = '0;
    pa_alt_en[3] = alt_ctrl[ALT_A3_PWM2]; // R04
    pa_alt_val[3] = second_timer_pwm_out; // R04
    pb_alt_en[4] = alt_ctrl[ALT_B4_PWM2]; // R04
    pb_alt_val[4] = second_timer_pwm_out; // R04
    pb_alt_en[2] = alt_ctrl[ALT_B2_PWM2]; // R04
    pb_alt_val[2] = second_timer_pwm_out; // R04
    pb_alt_en[7] = alt_ctrl[ALT_B7_PWM3]; // R05
    pb_alt_val[7] = third_timer_pwm_out; // R05
    pb_alt_en[6] = alt_ctrl[ALT_B6_PWM3]; // R05
    pb_alt_val[6] = third_timer_pwm_out; // R05
    pb_alt_en[5] = alt_ctrl[ALT_B5_PWM3]; // R05
    pb_alt_val[5] = third_timer_pwm_out; // R05
    pa_alt_en[0] = alt_ctrl[ALT_A0_COMP]; // R06
    pa_alt_val[0] = comparator_result; // R06
  end

  // pad control next values; analog use drops driver and pulls
  always_comb begin
    next_pa.out = ((pa_alt_en & pa_alt_val) | (~pa_alt_en & pa_data)) & PA_MASK; // R01
    next_pa.oe = (pa_alt_en | pa_dir) & ~pa_ana & PA_MASK; // R01
    next_pa.pull_up = pa_pu & ~pa_ana; // R01
    next_pa.pull_down = '0;
    next_pa.in_en = pa_ie; // R11
    next_pb.out = ((pb_alt_en & pb_alt_val) | (~pb_alt_en & pb_data)) & PB_MASK; // R01
    next_pb.oe = (pb_alt_en | pb_dir) & ~pb_ana & PB_MASK; // R01
    next_pb.pull_up = pb_pu & ~pb_ana; // R01
    next_pb.pull_down = pb_pd & ~pb_ana & PB_PD_MASK; // R02
    next_pb.in_en = pb_ie; // R11
  end

  // analog switches for adc channels and comparator minus sources
  always_comb begin
    next_adc = '0;
    next_cmpn = '0;
    next_adc[CH_A3] = pa_ana[3]; // R03
    next_cmpn[CMPN_A3] = pa_ana[3]; // R03
    next_adc[CH_A0] = pa_ana[0]; // R06
    next_adc[CH_PB_BASE + 5] = pb_ana[5]; // R08
    next_adc[CH_PB_BASE + 7] = pb_ana[7]; // R09
    next_adc[CH_PB_BASE + 6] = pb_ana[6]; // R09
    next_cmpn[CMPN_B7] = pb_ana[7]; // R09
    next_cmpn[CMPN_B6] = pb_ana[6]; // R09
    next_adc[CH_PB_BASE + 4] = pb_ana[4]; // R10
    next_adc[CH_PB_BASE + 3] = pb_ana[3]; // R10
    next_adc[CH_PB_BASE + 2] = pb_ana[2]; // R10
  end

  // registered pad and analog outputs
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      port_a_pad <= '0;
      port_b_pad <= '0;
      adc_channel_en <= '0;
      comparator_neg_en <= '0;
    end else begin
      port_a_pad <= next_pa;
      port_b_pad <= next_pb;
      adc_channel_en <= next_adc;
      comparator_neg_en <= next_cmpn;
    end
  end

  // gated input sampling; a disabled buffer reads as zero
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pa_sample <= '0;
      pb_sample <= '0;
      pa_prev <= '0;
      pb_prev <= '0;
    end else begin
      pa_sample <= port_a_pin_in & pa_ie; // R11 R12
      pb_sample <= port_b_pin_in & pb_ie; // R11
      pa_prev <= pa_sample;
      pb_prev <= pb_sample;
    end
  end

  // irq line 0 source select and edge detection
  assign next_irq0 = alt_ctrl[ALT_IRQ0_SRC] ? pb_sample[5] : pa_sample[0]; // R06 R08
  assign irq0_event = (next_irq0 && !irq0_prev && alt_ctrl[ALT_EDGE_RISE])
                   || (!next_irq0 && irq0_prev && alt_ctrl[ALT_EDGE_FALL]); // R07

  // wake-up on any enabled pin changing during power-down
  assign wake_event = power_down && (((pa_sample ^ pa_prev) | (pb_sample ^ pb_prev)) != 8'h00); // R13 R11 R12

  // irq line state and request pulses
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq0_prev <= 1'b0;
      ext_irq_line_zero <= 1'b0;
      ext_irq_req <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      irq0_prev <= next_irq0;
      ext_irq_line_zero <= next_irq0;
      ext_irq_req <= irq0_event; // R07
      wake_req <= wake_event; // R13
    end
  end

  // sticky status, write one to clear, a new event wins
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_LINE0] = irq0_event;
    irq_set[IRQ_WAKE] = wake_event;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat <= '0;
      irq <= 1'b0;
    end else begin
      if (hit(wr_en, paddr, OFS_IRQ_STAT)) begin
        irq_stat <= (irq_stat & ~pwdata[IRQ_W-1:0]) | irq_set;
      end else begin
        irq_stat <= irq_stat | irq_set;
      end
      irq <= |(irq_stat & irq_mask);
    end
  end

endmodule // port_pin_function_mux

/* pin_mux_pkg.sv */
package pin_mux_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] OFS_PA_IE = 8'h00;
  localparam logic [7:0] OFS_PB_IE = 8'h04;
  localparam logic [7:0] OFS_PA_DATA = 8'h08;
  localparam logic [7:0] OFS_PA_DIR = 8'h0c;
  localparam logic [7:0] OFS_PA_PU = 8'h10;
  localparam logic [7:0] OFS_PB_DATA = 8'h14;
  localparam logic [7:0] OFS_PB_DIR = 8'h18;
  localparam logic [7:0] OFS_PB_PU = 8'h1c;
  localparam logic [7:0] OFS_PB_PD = 8'h20;
  localparam logic [7:0] OFS_ALT = 8'h24;
  localparam logic [7:0] OFS_ANALOG = 8'h28;
  localparam logic [7:0] OFS_PA_IN = 8'h2c;
  localparam logic [7:0] OFS_PB_IN = 8'h30;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h34;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h38;
  // pins handled by this block
  localparam logic [7:0] PA_MASK = 8'h09;
  localparam logic [7:0] PB_MASK = 8'hfc;
  localparam logic [7:0] PB_PD_MASK = 8'h48;
  // reset values
  localparam logic [7:0] IE_RESET = 8'hff;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // alternate function control fields
  localparam int ALT_A3_PWM2 = 0;
  localparam int ALT_B4_PWM2 = 1;
  localparam int ALT_B2_PWM2 = 2;
  localparam int ALT_B7_PWM3 = 3;
  localparam int ALT_B6_PWM3 = 4;
  localparam int ALT_B5_PWM3 = 5;
  localparam int ALT_A0_COMP = 6;
  localparam int ALT_IRQ0_SRC = 7;
  localparam int ALT_EDGE_RISE = 8;
  localparam int ALT_EDGE_FALL = 9;
  localparam int ALT_W = 10;
  // analog enable: port a in bits 7:0, port b in bits 15:8
  localparam int ANA_PB_LSB = 8;
  localparam int ANA_W = 16;
  // adc channel of each covered pin
  localparam int ADC_CH_W = 11;
  localparam int CH_A3 = 8;
  localparam int CH_A0 = 10;
  localparam int CH_PB_BASE = 0;
  // comparator minus sources
  localparam int CMPN_W = 6;
  localparam int CMPN_A3 = 0;
  localparam int CMPN_B6 = 4;
  localparam int CMPN_B7 = 5;
  // interrupt status bits
  localparam int IRQ_LINE0 = 0;
  localparam int IRQ_WAKE = 1;
  localparam int IRQ_W = 2;

  // per-port pad controls
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull_up;
    logic [7:0] pull_down;
    logic [7:0] in_en;
  } pad_ctrl_s;
endpackage

/* pin_mux_assertions.sv */
`timescale 1ns/1ps
module pin_mux_assertions
  import pin_mux_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic [7:0] paddr, // apb byte address
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire pad_ctrl_s port_a_pad, // port a pads
  input wire pad_ctrl_s port_b_pad, // port b pads
  input wire logic [ADC_CH_W-1:0] adc_channel_en, // adc switches
  input wire logic power_down, // power-down level
  input wire logic wake_req // wake-up pulse
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // apb answer: exactly one wait state, one-cycle ready, error on unmapped words
  a_ready_one_wait: assert property ((psel && penable && !pready) |=> pready)
    else $error("pready not one cycle after access start");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_decode: assert property ((psel && penable && !pready) |=>
    (pslverr == (paddr > OFS_IRQ_MASK || paddr[1:0] != 2'b00))) else $error("pslverr wrong");
  // pull-down exists only on two port b pins
  a_pd_only_two: assert property ((port_b_pad.pull_down & ~PB_PD_MASK) == 8'h00
    && port_a_pad.pull_down == 8'h00) else $error("pull-down on wrong pin");
  // nothing driven or pulled up on pins outside this block
  a_pads_covered: assert property (((port_a_pad.oe | port_a_pad.pull_up) & ~PA_MASK) == 0
    && ((port_b_pad.oe | port_b_pad.pull_up) & ~PB_MASK) == 0) else $error("uncovered pad");
  // input enables come up set right after reset
  a_ie_reset: assert property ($rose(reset_n) |=> port_a_pad.in_en == PA_MASK
    && port_b_pad.in_en == PB_MASK) else $error("input enable reset value");
  // an analog pin on port b bits 7:2 or port a bit 3 is never driven
  a_analog_no_drive: assert property ((adc_channel_en[7:2] & port_b_pad.oe[7:2]) == 6'h00
    && !(adc_channel_en[CH_A3] && port_a_pad.oe[3])) else $error("analog pin driven");
  // wake requests only come out of power-down
  a_wake_in_pd: assert property (wake_req |-> $past(power_down))
    else $error("wake outside power-down");
endmodule // pin_mux_assertions

bind port_pin_function_mux pin_mux_assertions u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .port_a_pad(port_a_pad), .port_b_pad(port_b_pad), .adc_channel_en(adc_channel_en),
  .power_down(power_down), .wake_req(wake_req));

/* board_model.sv */
`timescale 1ns/1ps
module board_model
  import pin_mux_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire pad_ctrl_s pad_a, // port a pad controls
  input wire pad_ctrl_s pad_b, // port b pad controls
  input wire logic [15:0] ext_en, // board drives pin, b in 15:8
  input wire logic [15:0] ext_val, // board level, b in 15:8
  output logic [15:0] pin, // resolved pin levels
  output logic pwm2, // second timer pwm
  output logic pwm3 // third timer pwm
);
  logic [15:0] oe, drv, pu, pd;
  logic [15:0] lvl = 16'h0000;
  logic [3:0] cnt = 4'h0;
  // gather both ports into one vector
  assign oe = {pad_b.oe, pad_a.oe};
  assign drv = {pad_b.out, pad_a.out};
  assign pu = {pad_b.pull_up, pad_a.pull_up};
  assign pd = {pad_b.pull_down, pad_a.pull_down};
  assign pin = lvl;
  assign pwm2 = cnt[1];
  assign pwm3 = cnt[2];
  // pad drive wins, then board, then pulls; an open pin flips each cycle
  always @(posedge clk_sys) begin
    lvl <= (oe & drv) | (~oe & ext_en & ext_val)
      | (~oe & ~ext_en & (pu | (~pd & ~lvl)));
    cnt <= cnt + 4'h1;
  end
endmodule // board_model

/* tb_top.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %0t %h %h", $time, g, e); end end
module tb_top;
  import pin_mux_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] ext_en = 16'hffff;
  logic [15:0] ext_val = 16'h0000;
  logic comp = 1'b0;
  logic power_down = 1'b0;
  logic [31:0] prdata, rdata;
  logic pready, pslverr, rerr, pwm2, pwm3, p2, p3;
  logic eirq_lvl, eirq_req, wake_req, irq, seen_irq, seen_wake;
  pad_ctrl_s pad_a, pad_b;
  logic [15:0] pin;
  logic [10:0] adc_en;
  logic [5:0] cmp_en;
  int err_count = 0;
  int check_count = 0;

  always #10 clk_sys = ~clk_sys;

  port_pin_function_mux DUT (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_a_pin_in(pin[7:0]), .port_b_pin_in(pin[15:8]),
    .port_a_pad(pad_a), .port_b_pad(pad_b), .second_timer_pwm_out(pwm2),
    .third_timer_pwm_out(pwm3), .comparator_result(comp), .adc_channel_en(adc_en),
    .comparator_neg_en(cmp_en), .ext_irq_line_zero(eirq_lvl), .ext_irq_req(eirq_req),
    .power_down(power_down), .wake_req(wake_req), .irq(irq));

  board_model board (.clk_sys(clk_sys), .pad_a(pad_a), .pad_b(pad_b), .ext_en(ext_en),
    .ext_val(ext_val), .pin(pin), .pwm2(pwm2), .pwm3(pwm3));

  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1);
    `CHK(n, 2)
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK(rdata, x)
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // move one board pin, then watch edge and wake pulses for 8 cycles
  task automatic go(input int b, input logic v, input logic xi, input logic xw);
    ext_val[b] <= v;
    seen_irq = 1'b0;
    seen_wake = 1'b0;
    repeat (8) begin
      @(posedge clk_sys);
      seen_irq = seen_irq | (eirq_req === 1'b1);
      seen_wake = seen_wake | (wake_req === 1'b1);
    end
    `CHK({seen_irq, seen_wake}, {xi, xw})
  endtask

  task automatic t_reset;
    `CHK(pad_a.in_en, PA_MASK)
    `CHK(pad_b.in_en, PB_MASK)
    rd(OFS_PB_IE, {24'h0, PB_MASK});
    wr(8'h3c, 32'hff);
    `CHK(rerr, 1'b1)
    rd(8'h3c, 32'h0);
    `CHK(rerr, 1'b1)
  endtask
  task automatic t_gpio;
    ext_en <= 16'h0000;
    wr(OFS_PA_PU, 32'hff);
    wr(OFS_PB_PU, 32'hff);
    wr(OFS_PB_PD, 32'hff);
    `CHK(pad_a.pull_up, PA_MASK)
    cyc(2);
    rd(OFS_PB_IN, {24'h0, PB_MASK});
    wr(OFS_PB_PU, 32'h0);
    `CHK({pad_b.pull_up, pad_b.pull_down}, {8'h00, PB_PD_MASK})
    wr(OFS_PA_DIR, 32'hff);
    wr(OFS_PA_DATA, 32'h08);
    `CHK({pad_a.oe, pad_a.out}, {PA_MASK, 8'h08})
    wr(OFS_PB_DIR, 32'hff);
    wr(OFS_PB_DATA, 32'ha4);
    `CHK({pad_b.oe, pad_b.out}, {PB_MASK, 8'ha4})
    wr(OFS_PB_DIR, 32'h0);
    cyc(2);
    rd(OFS_PA_IN, 32'h08);
    wr(OFS_PA_DIR, 32'h0);
    ext_en <= 16'hffff;
  endtask
  task automatic t_alt;
    comp <= 1'b1;
    wr(OFS_ALT, 32'h07f);
    `CHK({pad_a.oe, pad_b.oe}, {PA_MASK, 8'hf4})
    repeat (4) begin
      #1;
      p2 = pwm2;
      p3 = pwm3;
      cyc(2);
      `CHK({pad_a.out[3], pad_b.out[4], pad_b.out[2]}, {3{p2}})
      `CHK({pad_b.out[7:5], pad_a.out[0]}, {{3{p3}}, 1'b1})
    end
    wr(OFS_ALT, 32'h0);
  endtask
  task automatic t_analog;
    wr(OFS_ANALOG, 32'hfc09);
    `CHK(adc_en, 11'h5fc)
    `CHK(cmp_en, 6'h31)
    `CHK({pad_a.pull_up, pad_b.pull_down}, 16'h0000)
    wr(OFS_ANALOG, 32'h0);
  endtask
  task automatic t_irq;
    wr(OFS_IRQ_MASK, 32'h1);
    wr(OFS_ALT, 32'h100);
    go(0, 1'b1, 1'b1, 1'b0);
    `CHK(irq, 1'b1)
    rd(OFS_IRQ_STAT, 32'h1);
    wr(OFS_IRQ_STAT, 32'h1);
    cyc(1);
    `CHK(irq, 1'b0)
    go(0, 1'b0, 1'b0, 1'b0);
    wr(OFS_ALT, 32'h200);
    go(0, 1'b1, 1'b0, 1'b0);
    go(0, 1'b0, 1'b1, 1'b0);
    wr(OFS_ALT, 32'h380);
    go(13, 1'b1, 1'b1, 1'b0);
    `CHK(eirq_lvl, 1'b1)
    go(0, 1'b1, 1'b0, 1'b0);
    wr(OFS_IRQ_MASK, 32'h0);
    go(13, 1'b0, 1'b1, 1'b0);
    `CHK(irq, 1'b0)
    wr(OFS_IRQ_MASK, 32'h1);
    cyc(1);
    `CHK(irq, 1'b1)
    wr(OFS_IRQ_STAT, 32'h3);
    wr(OFS_ALT, 32'h0);
  endtask
  task automatic t_wake;
    power_down <= 1'b1;
    go(3, 1'b1, 1'b0, 1'b1);
    wr(OFS_PA_IE, 32'h08);
    wr(OFS_PB_IE, 32'h0);
    cyc(4);
    go(0, 1'b0, 1'b0, 1'b0);
    go(10, 1'b1, 1'b0, 1'b0);
    power_down <= 1'b0;
    go(3, 1'b0, 1'b0, 1'b0);
    go(0, 1'b1, 1'b0, 1'b0);
    rd(OFS_PA_IN, 32'h0);
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    cyc(16);
    reset_n <= 1'b1;
    cyc(2);
    t_reset;
    t_gpio;
    t_alt;
    t_analog;
    t_irq;
    t_wake;
    end_sim;
  end
  // watchdog well beyond the expected run
  initial begin
    cyc(5000);
    err_count++;
    end_sim;
  end
endmodule // tb_top
